// ---- hw/sfe_pkg.sv ----
// constants and types shared by the serial flash erase command block
package sfe_pkg;

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  localparam logic [5:0] SFE_CMD_BITS    = 6'h08;
  localparam logic [5:0] SFE_ADDR3_BITS  = 6'h20;
  localparam logic [5:0] SFE_ADDR4_BITS  = 6'h28;
  localparam logic [5:0] SFE_BITS_MAX    = 6'h3F;
  localparam logic [5:0] SFE_SERIAL_STEP = 6'h01;
  localparam logic [5:0] SFE_QUAD_STEP   = 6'h04;
  localparam int         SFE_SHIFT_W     = 40;

  // ----------------------------------------------------------------
  // command codes (defaults of the top-level parameters)
  // ----------------------------------------------------------------
  localparam logic [7:0] SFE_WRITE_ENABLE_CMD_CODE   = 8'h06;
  localparam logic [7:0] SFE_SE_CODE     = 8'h20;
  localparam logic [7:0] SFE_HBE_CODE    = 8'h52;
  localparam logic [7:0] SFE_BE_CODE     = 8'hD8;
  localparam logic [7:0] SFE_CE_CODE     = 8'hC7;
  localparam logic [7:0] SFE_CE_ALT_CODE = 8'h60;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int SFE_ADDR_W      = 25;
  localparam int SFE_SECTOR_LSB  = 12;
  localparam int SFE_HALF_LSB    = 15;
  localparam int SFE_BLOCK_LSB   = 16;

  // ----------------------------------------------------------------
  // erase cycle lengths in clk cycles (plain defaults)
  // ----------------------------------------------------------------
  localparam int SFE_TIMER_W       = 24;
  localparam int SFE_SE_CYCLES_DEF = 2000;
  localparam int SFE_HBE_CYCLES_DEF = 4000;
  localparam int SFE_BE_CYCLES_DEF = 6000;
  localparam int SFE_CE_CYCLES_DEF = 20000;

  typedef enum logic [1:0] {
    SFE_SIZE_SECTOR = 2'b00,
    SFE_SIZE_HALF   = 2'b01,
    SFE_SIZE_BLOCK  = 2'b10,
    SFE_SIZE_CHIP   = 2'b11
  } sfe_size_t;

  typedef enum logic [1:0] {
    SFE_IDLE  = 2'b00,
    SFE_SWEEP = 2'b01,
    SFE_BUSY  = 2'b10
  } sfe_state_t;

endpackage : sfe_pkg

// ---- hw/sfe_timer_if.sv ----
// handshake between the erase sequencer and its cycle timer
`timescale 1ns/1ns
interface sfe_timer_if;
  import sfe_pkg::*;
  logic                   start;
  logic [SFE_TIMER_W-1:0] cycles;
  logic                   busy;
  logic                   done;
  modport ctrl  (output start, output cycles, input busy, input done);
  modport timer (input start, input cycles, output busy, output done);
endinterface : sfe_timer_if

// ---- hw/sfe_sync.sv ----
// two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sfe_sync #(
  parameter int        W     = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sfe_sync

// ---- hw/sfe_timer.sv ----
// self-timed erase cycle counter
`timescale 1ns/1ns
module sfe_timer
  import sfe_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  sfe_timer_if.timer tif
);
  logic [SFE_TIMER_W-1:0] remain;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      remain   <= '0;
      tif.busy <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      tif.done <= 1'b0;
      if (tif.start && !tif.busy) begin
        remain   <= tif.cycles;
        tif.busy <= 1'b1;
      end else if (tif.busy) begin
        if (remain <= SFE_TIMER_W'(1)) begin
          tif.busy <= 1'b0;
          tif.done <= 1'b1;
        end else begin
          remain <= remain - SFE_TIMER_W'(1);
        end
      end
    end
  end
endmodule : sfe_timer

// ---- hw/sfe_erase.sv ----
// erase command decoder and sequencer of the serial flash device
`timescale 1ns/1ns

// Functional notes
// - sector erase sets addressed 4 KB to ones
// - sector chosen by address bits 12 upward
// - addressed erase needs exact final-byte boundary
// - three-byte default; wide mode or extension bit
// - code as 8 serial or 2 quad clocks
// - serial mode ignores upper data lines
// - erase starts at closing select rise
// - busy flag during sector erase, latch cleared
// - protected target refused per protect mode
// - half block chosen by bits 15 upward
// - block erase sets addressed 64 KB ones
// - busy through block erase, then both clear
// - chip erase: code only, whole array
// - chip erase needs exact code boundary
// - block-protect mode: chip erase needs zero bits
// - sector-protect mode skips protected blocks
// - edge blocks skipped if any sector protected; the sweep skips only blocks whose sector_block_protect bit is set
module sfe_erase
  import sfe_pkg::*;
#(
  parameter int         ADDR_W      = SFE_ADDR_W,
  parameter int         NUM_BLOCKS  = 512,
  parameter int         SE_CYCLES   = SFE_SE_CYCLES_DEF,
  parameter int         HBE_CYCLES  = SFE_HBE_CYCLES_DEF,
  parameter int         BE_CYCLES   = SFE_BE_CYCLES_DEF,
  parameter int         CE_CYCLES   = SFE_CE_CYCLES_DEF,
  parameter logic [7:0] WRITE_ENABLE_CMD_CODE   = SFE_WRITE_ENABLE_CMD_CODE,
  parameter logic [7:0] SE_CODE     = SFE_SE_CODE,
  parameter logic [7:0] HBE_CODE    = SFE_HBE_CODE,
  parameter logic [7:0] BE_CODE     = SFE_BE_CODE,
  parameter logic [7:0] CE_CODE     = SFE_CE_CODE,
  parameter logic [7:0] CE_ALT_CODE = SFE_CE_ALT_CODE
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  cs_n,
  input  wire logic                  sclk,
  input  wire logic [3:0]            sio_in,
  input  wire logic                  quad_command_mode,
  input  wire logic                  wide_address_mode,
  input  wire logic                  extended_address_bit,
  input  wire logic                  protect_mode_select,
  input  wire logic [3:0]            block_protect_bits,
  input  wire logic [NUM_BLOCKS-1:0] bp_block_protect,
  input  wire logic [NUM_BLOCKS-1:0] sector_block_protect,
  output logic                       write_enable_latch,
  output logic                       write_in_progress_flag,
  output logic                       erase_strobe,
  output logic [ADDR_W-1:0]          erase_base,
  output sfe_size_t                  erase_size,
  output logic                       cmd_rejected
);

  localparam int BLK_W = $clog2(NUM_BLOCKS);

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] sio_s;
  logic       cs_n_d;
  logic       sclk_d;

  sfe_sync #(.W(1), .RST_VAL(1'b1)) u_sync_cs (
    .clk  (clk),
    .nrst (nrst),
    .d    (cs_n),
    .q    (cs_n_s)
  );

  sfe_sync #(.W(1), .RST_VAL(1'b0)) u_sync_sclk (
    .clk  (clk),
    .nrst (nrst),
    .d    (sclk),
    .q    (sclk_s)
  );

  sfe_sync #(.W(4), .RST_VAL(4'h0)) u_sync_sio (
    .clk  (clk),
    .nrst (nrst),
    .d    (sio_in),
    .q    (sio_s)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;

  assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;
  assign cs_rise   = cs_n_s && !cs_n_d;
  assign cs_fall   = !cs_n_s && cs_n_d;

  // ----------------------------------------------------------------
  // bit shifter and counter
  // ----------------------------------------------------------------
  logic [SFE_SHIFT_W-1:0] shift;
  logic [5:0]             bit_cnt;
  logic [5:0]             step;

  assign step = quad_command_mode ? SFE_QUAD_STEP : SFE_SERIAL_STEP;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else if (cs_fall) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      if (quad_command_mode) begin
        shift <= {shift[SFE_SHIFT_W-5:0], sio_s};
      end else begin
        shift <= {shift[SFE_SHIFT_W-2:0], sio_s[0]};
      end
      if (bit_cnt > SFE_BITS_MAX - step) begin
        bit_cnt <= SFE_BITS_MAX;
      end else begin
        bit_cnt <= bit_cnt + step;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame decode at the closing select edge
  // ----------------------------------------------------------------
  logic [7:0]        code_short;
  logic [7:0]        code_addr;
  logic [ADDR_W-1:0] addr;
  logic              addr_frame;
  logic              short_frame;
  logic              is_se;
  logic              is_hbe;
  logic              is_be;
  logic              is_ce;
  logic              is_write_enable_cmd;
  logic [BLK_W-1:0]  tgt_blk;
  logic              tgt_prot;
  logic [ADDR_W-1:0] base_se;
  logic [ADDR_W-1:0] base_hbe;
  logic [ADDR_W-1:0] base_be;

  assign short_frame = (bit_cnt == SFE_CMD_BITS);
  assign addr_frame  = wide_address_mode ? (bit_cnt == SFE_ADDR4_BITS)
                                         : (bit_cnt == SFE_ADDR3_BITS);
  assign code_short  = shift[7:0];
  assign code_addr   = wide_address_mode ? shift[39:32] : shift[31:24];

  // the extension bit sits just above the three address bytes; a small array drops it
  localparam int A3_W = int'(SFE_ADDR3_BITS) - int'(SFE_CMD_BITS);

  logic [A3_W:0] addr3;

  assign addr3 = {extended_address_bit, shift[A3_W-1:0]};

  always_comb begin
    addr = '0;
    if (wide_address_mode) begin
      addr = shift[ADDR_W-1:0];
    end else begin
      addr = addr3[ADDR_W-1:0];
    end
  end

  assign is_se   = addr_frame && (code_addr == SE_CODE);
  assign is_hbe  = addr_frame && (code_addr == HBE_CODE);
  assign is_be   = addr_frame && (code_addr == BE_CODE);
  assign is_ce   = short_frame && ((code_short == CE_CODE) || (code_short == CE_ALT_CODE));
  assign is_write_enable_cmd = short_frame && (code_short == WRITE_ENABLE_CMD_CODE);

  assign tgt_blk  = addr[SFE_BLOCK_LSB +: BLK_W];
  assign tgt_prot = protect_mode_select ? sector_block_protect[tgt_blk]
                                        : bp_block_protect[tgt_blk];
  assign base_se  = {addr[ADDR_W-1:SFE_SECTOR_LSB], {SFE_SECTOR_LSB{1'b0}}};
  assign base_hbe = {addr[ADDR_W-1:SFE_HALF_LSB], {SFE_HALF_LSB{1'b0}}};
  assign base_be  = {addr[ADDR_W-1:SFE_BLOCK_LSB], {SFE_BLOCK_LSB{1'b0}}};

  logic accept_addr;
  logic accept_ce;
  logic busy_any;

  assign busy_any    = write_in_progress_flag;
  assign accept_addr = cs_rise && (is_se || is_hbe || is_be) && write_enable_latch
                       && !busy_any && !tgt_prot;
  assign accept_ce   = cs_rise && is_ce && write_enable_latch && !busy_any
                       && (protect_mode_select || (block_protect_bits == 4'h0));

  // ----------------------------------------------------------------
  // erase sequencer
  // ----------------------------------------------------------------
  sfe_timer_if tif ();

  sfe_timer u_timer (
    .clk  (clk),
    .nrst (nrst),
    .tif  (tif)
  );

  sfe_state_t       state;
  logic [BLK_W-1:0] sweep_blk;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state                  <= SFE_IDLE;
      sweep_blk              <= '0;
      write_in_progress_flag <= 1'b0;
      erase_strobe           <= 1'b0;
      erase_base             <= '0;
      erase_size             <= SFE_SIZE_SECTOR;
      tif.start              <= 1'b0;
      tif.cycles             <= '0;
    end else begin
      erase_strobe <= 1'b0;
      tif.start    <= 1'b0;
      unique case (state)
        SFE_IDLE: begin
          if (accept_addr) begin
            erase_strobe           <= 1'b1;
            write_in_progress_flag <= 1'b1;
            state                  <= SFE_BUSY;
            tif.start              <= 1'b1;
            if (is_se) begin
              erase_base <= base_se;
              erase_size <= SFE_SIZE_SECTOR;
              tif.cycles <= SFE_TIMER_W'(SE_CYCLES);
            end else if (is_hbe) begin
              erase_base <= base_hbe;
              erase_size <= SFE_SIZE_HALF;
              tif.cycles <= SFE_TIMER_W'(HBE_CYCLES);
            end else begin
              erase_base <= base_be;
              erase_size <= SFE_SIZE_BLOCK;
              tif.cycles <= SFE_TIMER_W'(BE_CYCLES);
            end
          end else if (accept_ce) begin
            write_in_progress_flag <= 1'b1;
            tif.cycles             <= SFE_TIMER_W'(CE_CYCLES);
            if (protect_mode_select) begin
              sweep_blk <= '0;
              state     <= SFE_SWEEP;
            end else begin
              erase_strobe <= 1'b1;
              erase_base   <= '0;
              erase_size   <= SFE_SIZE_CHIP;
              tif.start    <= 1'b1;
              state        <= SFE_BUSY;
            end
          end
        end
        SFE_SWEEP: begin
          if (!sector_block_protect[sweep_blk]) begin
            erase_strobe <= 1'b1;
            erase_base   <= {sweep_blk, {SFE_BLOCK_LSB{1'b0}}};
            erase_size   <= SFE_SIZE_BLOCK;
          end
          if (sweep_blk == BLK_W'(NUM_BLOCKS - 1)) begin
            tif.start <= 1'b1;
            state     <= SFE_BUSY;
          end else begin
            sweep_blk <= sweep_blk + BLK_W'(1);
          end
        end
        SFE_BUSY: begin
          if (tif.done) begin
            write_in_progress_flag <= 1'b0;
            state                  <= SFE_IDLE;
          end
        end
        default: begin
          state <= SFE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write-enable latch and reject flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0;
    end else if (state == SFE_BUSY && tif.done) begin
      write_enable_latch <= 1'b0;
    end else if (cs_rise && is_write_enable_cmd && !busy_any) begin
      write_enable_latch <= 1'b1;
    end
  end

  logic [7:0] first_code;

  // keeps the opening byte so a frame of the wrong length is still recognised
  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_code <= 8'h00;
    end else if (cs_fall) begin
      first_code <= 8'h00;
    end else if (bit_cnt == SFE_CMD_BITS) begin
      first_code <= shift[7:0];
    end
  end

  logic any_erase_code;

  assign any_erase_code = (first_code == SE_CODE) || (first_code == HBE_CODE)
                          || (first_code == BE_CODE) || (first_code == CE_CODE)
                          || (first_code == CE_ALT_CODE);

  // pulses when an erase frame closed without starting anything, except an 8-bit address-erase frame or an address-length chip erase frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_rejected <= 1'b0;
    end else begin
      cmd_rejected <= cs_rise && !accept_addr && !accept_ce
                      && (is_se || is_hbe || is_be || is_ce
                          || (bit_cnt != SFE_CMD_BITS && bit_cnt != '0
                              && !addr_frame && any_erase_code));
    end
  end

endmodule : sfe_erase

// ---- tb/sfe_erase_monitor.sv ----
// concurrent checks on the erase sequencer ports
`timescale 1ns/1ns
module sfe_erase_monitor
  import sfe_pkg::*;
#(
  parameter int ADDR_W     = SFE_ADDR_W,
  parameter int NUM_BLOCKS = 512
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  cs_n,
  input wire logic                  sclk,
  input wire logic [3:0]            sio_in,
  input wire logic                  quad_command_mode,
  input wire logic                  wide_address_mode,
  input wire logic                  extended_address_bit,
  input wire logic                  protect_mode_select,
  input wire logic [3:0]            block_protect_bits,
  input wire logic [NUM_BLOCKS-1:0] bp_block_protect,
  input wire logic [NUM_BLOCKS-1:0] sector_block_protect,
  input wire logic                  write_enable_latch,
  input wire logic                  write_in_progress_flag,
  input wire logic                  erase_strobe,
  input wire logic [ADDR_W-1:0]     erase_base,
  input wire sfe_size_t             erase_size,
  input wire logic                  cmd_rejected
);
  // ----------------------------------------------------------------
  // erase start, busy and target checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [ADDR_W-SFE_BLOCK_LSB-1:0] blk;
  assign blk = erase_base[ADDR_W-1:SFE_BLOCK_LSB];
  a_strobe_when_busy: assert property (erase_strobe |-> write_in_progress_flag)
    else $error("erase strobe without busy flag");
  a_busy_needs_latch: assert property ($rose(write_in_progress_flag) |-> write_enable_latch)
    else $error("busy started with latch clear");
  a_start_deselect: assert property ($rose(write_in_progress_flag) |-> cs_n && $past(cs_n))
    else $error("busy started while selected");
  a_busy_holds: assert property ($rose(write_in_progress_flag) |-> write_in_progress_flag [*8])
    else $error("busy flag dropped early");
  a_done_clears_latch: assert property ($fell(write_in_progress_flag) |-> !write_enable_latch)
    else $error("latch still set after erase");
  a_reject_no_erase: assert property (cmd_rejected |-> !erase_strobe && !$rose(write_in_progress_flag))
    else $error("rejected frame still erased");
  a_sector_align: assert property (erase_strobe && erase_size == SFE_SIZE_SECTOR |-> erase_base[11:0] == 12'h000)
    else $error("sector base not aligned");
  a_half_align: assert property (erase_strobe && erase_size == SFE_SIZE_HALF |-> erase_base[14:0] == 15'h0000)
    else $error("half block base not aligned");
  a_block_align: assert property (erase_strobe && erase_size == SFE_SIZE_BLOCK |-> erase_base[15:0] == 16'h0000)
    else $error("block base not aligned");
  a_chip_unprotected: assert property (erase_strobe && erase_size == SFE_SIZE_CHIP
      |-> erase_base == '0 && !protect_mode_select && block_protect_bits == 4'h0)
    else $error("chip erase while protected");
  a_bp_target: assert property (erase_strobe && !protect_mode_select && erase_size != SFE_SIZE_CHIP
      |-> !bp_block_protect[blk])
    else $error("erase of block protected block");
  a_sp_target: assert property (erase_strobe && protect_mode_select
      |-> erase_size != SFE_SIZE_CHIP && !sector_block_protect[blk])
    else $error("erase of sector protected block");
endmodule : sfe_erase_monitor

bind sfe_erase sfe_erase_monitor #(.ADDR_W(ADDR_W), .NUM_BLOCKS(NUM_BLOCKS)) sfe_erase_monitor_inst (
  .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
  .quad_command_mode(quad_command_mode), .wide_address_mode(wide_address_mode),
  .extended_address_bit(extended_address_bit), .protect_mode_select(protect_mode_select),
  .block_protect_bits(block_protect_bits), .bp_block_protect(bp_block_protect),
  .sector_block_protect(sector_block_protect), .write_enable_latch(write_enable_latch),
  .write_in_progress_flag(write_in_progress_flag), .erase_strobe(erase_strobe),
  .erase_base(erase_base), .erase_size(erase_size), .cmd_rejected(cmd_rejected));

// ---- tb/sfe_host_model.sv ----
// host controller model driving the serial command pins
`timescale 1ns/1ns
module sfe_host_model (
  input  wire logic  clk,
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] sio_in
);
  // ----------------------------------------------------------------
  // frame driver, sclk idles low outside frames
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio_in = 4'hA;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // sends n bits of d from the top, one or four per sclk rise
  task automatic frame(input logic [39:0] d, input int n, input logic q);
    int i;
    tick(1);
    cs_n = 1'b0;
    for (i = 0; i < n; i += (q ? 4 : 1)) begin
      sclk = 1'b0;
      sio_in = q ? d[39-i -: 4] : {~sio_in[3:1], d[39-i]};
      tick(4);
      sclk = 1'b1;
      tick(4);
    end
    sclk = 1'b0;
    tick(4);
    cs_n = 1'b1;
    sio_in = ~sio_in;
    tick(8);
  endtask : frame
endmodule : sfe_host_model

// ---- tb/sfe_erase_tb.sv ----
// self-checking bench for the erase command sequencer
`timescale 1ns/1ns
module sfe_erase_tb;
  import sfe_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, quad_command_mode, wide_address_mode, extended_address_bit;
  logic protect_mode_select;
  logic [3:0] block_protect_bits, bp_block_protect, sector_block_protect;
  logic cs_n, sclk, write_enable_latch, write_in_progress_flag, erase_strobe, cmd_rejected;
  logic [3:0] sio_in;
  logic [17:0] erase_base, lb;
  sfe_size_t erase_size, lz;
  int fail_count = 0, total_checks = 0, strobes, rejects, cyc = 0;
  sfe_host_model sfe_host_model_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));
  sfe_erase #(.ADDR_W(18), .NUM_BLOCKS(4), .SE_CYCLES(10), .HBE_CYCLES(10), .BE_CYCLES(10),
    .CE_CYCLES(10)) sfe_erase_inst (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
    .quad_command_mode(quad_command_mode), .wide_address_mode(wide_address_mode),
    .extended_address_bit(extended_address_bit), .protect_mode_select(protect_mode_select),
    .block_protect_bits(block_protect_bits), .bp_block_protect(bp_block_protect),
    .sector_block_protect(sector_block_protect), .write_enable_latch(write_enable_latch),
    .write_in_progress_flag(write_in_progress_flag), .erase_strobe(erase_strobe),
    .erase_base(erase_base), .erase_size(erase_size), .cmd_rejected(cmd_rejected));
  // ----------------------------------------------------------------
  // clock, outcome watcher, timeout
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  always @(negedge clk) begin
    if (erase_strobe === 1'b1) begin
      strobes++;
      lb = erase_base;
      lz = erase_size;
    end
    if (cmd_rejected === 1'b1) rejects++;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // optional write enable, one erase frame, then wait out the busy time
  task automatic run(input int tn, input logic wr, input logic [7:0] code, input logic [31:0] a,
    input int n, input logic q, input int es, input int er, input logic [17:0] eb, input int ez);
    logic [39:0] d;
    int k;
    d = wide_address_mode ? {code, a} : {code, a[23:0], 8'h00};
    quad_command_mode = q;
    strobes = 0;
    rejects = 0;
    if (wr) sfe_host_model_inst.frame({SFE_WRITE_ENABLE_CMD_CODE, 32'h0000_0000}, 8, q);
    check("latch armed", write_enable_latch, wr);
    sfe_host_model_inst.frame(d, n, q);
    for (k = 0; k < 300 && write_in_progress_flag !== 1'b0; k++) @(posedge clk);
    #1;
    check("strobes", strobes, es);
    check("rejects", rejects, er);
    if (es == 1) check("base", lb, eb);
    if (es > 0) check("size", lz, ez);
    check("latch", write_enable_latch, wr && es == 0);
    check("busy", write_in_progress_flag, 1'b0);
    $display("test %0d done", tn);
  endtask : run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {quad_command_mode, wide_address_mode, extended_address_bit, protect_mode_select} = 4'h0;
    block_protect_bits = 4'h0;
    bp_block_protect = 4'h0;
    sector_block_protect = 4'h0;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    run(1, 1, 8'h20, 32'h0001_2345, 32, 0, 1, 0, 18'h12000, 0);
    run(7, 0, 8'h20, 32'h0001_2345, 32, 0, 0, 1, 18'h0, 0);
    run(2, 1, 8'h52, 32'h0002_ABCD, 32, 1, 1, 0, 18'h28000, 1);
    wide_address_mode = 1'b1;
    run(3, 1, 8'hD8, 32'h0003_FFFF, 40, 0, 1, 0, 18'h30000, 2);
    run(4, 1, 8'hD8, 32'h0003_FFFF, 32, 0, 0, 1, 18'h0, 0);
    wide_address_mode = 1'b0;
    run(5, 1, 8'h20, 32'h0001_2345, 31, 0, 0, 1, 18'h0, 0);
    run(6, 1, 8'h20, 32'h0001_2345, 33, 0, 0, 1, 18'h0, 0);
    bp_block_protect = 4'h2;
    run(8, 1, 8'h20, 32'h0001_0000, 32, 0, 0, 1, 18'h0, 0);
    run(9, 1, 8'h20, 32'h0000_F000, 32, 0, 1, 0, 18'h0F000, 0);
    run(10, 1, 8'hC7, 32'h0, 8, 0, 1, 0, 18'h0, 3);
    run(11, 1, 8'h60, 32'h0, 8, 1, 1, 0, 18'h0, 3);
    run(12, 1, 8'hC7, 32'h0, 16, 0, 0, 1, 18'h0, 0);
    block_protect_bits = 4'h4;
    run(13, 1, 8'hC7, 32'h0, 8, 0, 0, 1, 18'h0, 0);
    protect_mode_select = 1'b1;
    sector_block_protect = 4'h9;
    run(14, 1, 8'hC7, 32'h0, 8, 0, 2, 0, 18'h0, 2);
    run(15, 1, 8'h20, 32'h0003_1000, 32, 0, 0, 1, 18'h0, 0);
    extended_address_bit = 1'b1;
    run(16, 1, 8'h20, 32'h0001_5000, 32, 0, 1, 0, 18'h15000, 0);
    finish_test();
  end
endmodule : sfe_erase_tb
